// [hdl/watchdog_map.vh]
/*
 Register map, field positions, reset values, service keys and timing
 figures of the watchdog service timer.
 Assumes a 32-bit register port with byte addresses; data sit in the
 low 16 bits and upper bits read as zero.
*/
`ifndef WATCHDOG_MAP_VH
`define WATCHDOG_MAP_VH

// Register byte offsets
`define WD_OFF_CTRL 8'h00
`define WD_OFF_MODULUS 8'h04
`define WD_OFF_COUNT 8'h08
`define WD_OFF_SERVICE 8'h0c
`define WD_OFF_IRQ_STATUS 8'h10
`define WD_OFF_IRQ_ENABLE 8'h14
`define WD_OFF_IRQ_CLEAR 8'h18

// Control field positions
`define WD_CTRL_EN 0
`define WD_CTRL_HALTED 1
`define WD_CTRL_DOZE 2
`define WD_CTRL_WAIT 3
`define WD_CTRL_WIDTH 4

// Interrupt status bit positions
`define WD_IRQ_SERVICED 0
`define WD_IRQ_TIMEOUT 1
`define WD_IRQ_KEY_ERROR 2
`define WD_IRQ_WIDTH 3

// Reset values
`define WD_CTRL_RESET 4'he
`define WD_MOD_RESET 16'hffff

// Service keys
`define WD_KEY_FIRST 16'h5555
`define WD_KEY_SECOND 16'haaaa

// Prescaler divide ratio in system clocks
`define WD_PRESCALE_DIV 8192

`endif

// [hdl/wd_prescaler.v]
/*
 Prescaler of the watchdog: divides the system clock and gives one
 tick per DIV clocks while running.
 Assumes a synchronised active-low reset and a single clock.
*/
`timescale 1ns/100ps
`default_nettype none
`include "watchdog_map.vh"

module wd_prescaler
#(
   parameter DIV = `WD_PRESCALE_DIV
)
(
   // Clock and reset
   input wire ref_clk,
   input wire rst_n,
   // Control
   input wire run,
   input wire clear,
   // Terminal count
   output wire tick
);

   localparam WIDTH = (DIV > 1) ? $clog2(DIV) : 1;
   // Cut to the divider width on purpose; wraps right for powers of two
   localparam [WIDTH-1:0] LAST = DIV[WIDTH-1:0] - 1'b1;

   reg [WIDTH-1:0] preCount; // Divider state

   ////////////////////////////////////////////////////////////////////
   // Divider, cleared on reset and on every counter load
   always @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         preCount <= {WIDTH{1'b0}};
      end
      else if (clear)
      begin
         preCount <= {WIDTH{1'b0}};
      end
      else if (run)
      begin
         // Wrap at terminal count
         if (preCount == LAST)
            preCount <= {WIDTH{1'b0}};
         else
            preCount <= preCount + 1'b1;
      end
   end

   // Held still while not running
   assign tick = run && !clear && (preCount == LAST);

endmodule
`default_nettype wire

// [hdl/watchdog_service_timer.v]
/*
 Watchdog service timer: write-once control and modulus registers, a
 prescaled 16-bit down-counter, the two-key service sequence, the
 timeout request to the reset controller and an interrupt block.
 Assumes the bus master, halt and low-power mode flags run on ref_clk;
 the reset controller resets this block after a timeout.
*/
// The address-and-strobe port and the register offsets are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
`include "watchdog_map.vh"

module watchdog_service_timer
#(
   parameter PRESCALE_DIV = `WD_PRESCALE_DIV
)
(
   // Clock and reset
   input wire ref_clk,
   input wire rst_n,
   // Register port
   input wire [7:0] regAddr,
   input wire [31:0] regWrData,
   input wire regWrite,
   input wire regRead,
   output reg [31:0] regRdData,
   // Processor mode flags
   input wire haltedMode,
   input wire waitMode,
   input wire dozeMode,
   // Reset controller request
   output reg timeoutReset,
   // Interrupt
   output wire irq
);

   ////////////////////////////////////////////////////////////////////
   // Local constants

   // Service sequence states
   localparam [0:0] SVC_FIRST = 1'b0;
   localparam [0:0] SVC_SECOND = 1'b1;

   ////////////////////////////////////////////////////////////////////
   // Functions

   // Address match for a strobe
   function hit;
      input [7:0] addr;
      input [7:0] offset;
      input strobe;
      begin
         hit = strobe && (addr == offset);
      end
   endfunction

   ////////////////////////////////////////////////////////////////////
   // Declarations

   reg rstMeta_n; // Reset synchroniser first stage
   reg rstSync_n; // Synchronised reset used by the block

   reg [`WD_CTRL_WIDTH-1:0] ctrl; // Timer control register
   reg ctrlLocked; // Control already written
   reg [15:0] modulus; // Reload value field
   reg modLocked; // Modulus already written
   reg [15:0] count; // Current count field
   reg svcState; // Service sequence state
   reg [`WD_IRQ_WIDTH-1:0] irqStatus; // Sticky event bits
   reg [`WD_IRQ_WIDTH-1:0] irqEnable; // Interrupt enables
   reg [31:0] next_regRdData; // Read data for next cycle
   reg next_svcState; // Service state next value

   wire ctrlWr; // Control register written
   wire ctrlAccept; // Control write takes effect
   wire modWr; // Modulus register written
   wire modAccept; // Modulus write takes effect
   wire svcWr; // Service register written
   wire keyFirst; // First key seen
   wire keySecond; // Second key seen
   wire serviced; // Sequence completed
   wire keyError; // Sequence broken
   wire irqClrWr; // Interrupt clear written
   wire loadCount; // Any load of the counter
   wire enabled; // Enable bit
   wire stopped; // A stop condition is active
   wire running; // Counter may advance
   wire tick; // Prescaler terminal count
   wire expire; // Counter reached zero
   wire [`WD_IRQ_WIDTH-1:0] irqEvent; // Events this cycle

   ////////////////////////////////////////////////////////////////////
   // Reset release through two flip-flops
   always @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rstMeta_n <= 1'b0;
         rstSync_n <= 1'b0;
      end
      else
      begin
         rstMeta_n <= 1'b1;
         rstSync_n <= rstMeta_n;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Write decode

   // Control and modulus writes
   assign ctrlWr = hit(regAddr, `WD_OFF_CTRL, regWrite);
   assign modWr = hit(regAddr, `WD_OFF_MODULUS, regWrite);
   // Write-once guard lifted in halted mode
   assign ctrlAccept = ctrlWr && (!ctrlLocked || haltedMode);
   assign modAccept = modWr && (!modLocked || haltedMode);

   // Service key decode
   assign svcWr = hit(regAddr, `WD_OFF_SERVICE, regWrite);
   assign keyFirst = svcWr && (regWrData[15:0] == `WD_KEY_FIRST);
   assign keySecond = svcWr && (regWrData[15:0] == `WD_KEY_SECOND);
   // Second key only counts after the first
   assign serviced = keySecond && (svcState == SVC_SECOND);
   // Any other value breaks the sequence
   assign keyError = svcWr && !keyFirst && !keySecond;

   // Interrupt clear register
   assign irqClrWr = hit(regAddr, `WD_OFF_IRQ_CLEAR, regWrite);

   // Count writes have no decode at all and end like any write

   ////////////////////////////////////////////////////////////////////
   // Run conditions

   assign enabled = ctrl[`WD_CTRL_EN];
   // Low-power and halted stops
   assign stopped = (ctrl[`WD_CTRL_WAIT] && waitMode) ||
                    (ctrl[`WD_CTRL_DOZE] && dozeMode) ||
                    (ctrl[`WD_CTRL_HALTED] && haltedMode);
   assign running = enabled && !stopped;
   // Both load sources clear the prescaler
   assign loadCount = modAccept || serviced;

   ////////////////////////////////////////////////////////////////////
   // Prescaler
   wd_prescaler
   #(
      .DIV(PRESCALE_DIV)
   )
   u_prescaler
   (
      .ref_clk(ref_clk),
      .rst_n(rstSync_n),
      .run(running),
      .clear(loadCount),
      .tick(tick)
   );

   ////////////////////////////////////////////////////////////////////
   // Control register, write-once
   always @(posedge ref_clk or negedge rstSync_n)
   begin
      if (!rstSync_n)
      begin
         ctrl <= `WD_CTRL_RESET;
         ctrlLocked <= 1'b0;
      end
      else if (ctrlAccept)
      begin
         ctrl <= regWrData[`WD_CTRL_WIDTH-1:0];
         // Halted-mode writes leave the register open
         if (!haltedMode)
            ctrlLocked <= 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Modulus register, write-once
   always @(posedge ref_clk or negedge rstSync_n)
   begin
      if (!rstSync_n)
      begin
         modulus <= `WD_MOD_RESET;
         modLocked <= 1'b0;
      end
      else if (modAccept)
      begin
         // Kept for every later reload
         modulus <= regWrData[15:0];
         // Halted-mode writes leave the register open
         if (!haltedMode)
            modLocked <= 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Watchdog down-counter
   always @(posedge ref_clk or negedge rstSync_n)
   begin
      if (!rstSync_n)
      begin
         count <= `WD_MOD_RESET;
      end
      else if (modAccept)
      begin
         // New modulus goes straight in
         count <= regWrData[15:0];
      end
      else if (serviced)
      begin
         // Reload from stored modulus
         count <= modulus;
      end
      else if (tick && (count != 16'h0000))
      begin
         // One step per prescaler tick
         count <= count - 16'h0001;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Expiry and reset request

   // Zero while running without a pending reload
   assign expire = running && (count == 16'h0000) && !loadCount;

   // Request held until the system reset arrives
   always @(posedge ref_clk or negedge rstSync_n)
   begin
      if (!rstSync_n)
      begin
         timeoutReset <= 1'b0;
      end
      else if (expire)
      begin
         timeoutReset <= 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Service sequence state machine
   always @*
   begin
      next_svcState = svcState;
      case (svcState)
         SVC_FIRST:
         begin
            // Only the first key advances
            if (keyFirst)
               next_svcState = SVC_SECOND;
         end
         SVC_SECOND:
         begin
            // Done or broken both restart
            if (keySecond)
               next_svcState = SVC_FIRST;
            else if (keyError)
               next_svcState = SVC_FIRST;
         end
         default:
         begin
            next_svcState = SVC_FIRST;
         end
      endcase
   end

   // State register
   always @(posedge ref_clk or negedge rstSync_n)
   begin
      if (!rstSync_n)
         svcState <= SVC_FIRST;
      else
         svcState <= next_svcState;
   end

   ////////////////////////////////////////////////////////////////////
   // Interrupt block

   // Events of this cycle
   assign irqEvent[`WD_IRQ_SERVICED] = serviced;
   assign irqEvent[`WD_IRQ_TIMEOUT] = expire && !timeoutReset;
   assign irqEvent[`WD_IRQ_KEY_ERROR] = keyError;

   // Sticky bits, a new event wins over a clear
   genvar gi;
   generate
      for (gi = 0; gi < `WD_IRQ_WIDTH; gi = gi + 1)
      begin : g_sticky
         always @(posedge ref_clk or negedge rstSync_n)
         begin
            if (!rstSync_n)
               irqStatus[gi] <= 1'b0;
            else if (irqEvent[gi])
               irqStatus[gi] <= 1'b1;
            else if (irqClrWr && regWrData[gi])
               irqStatus[gi] <= 1'b0;
         end
      end
   endgenerate

   // Enable register
   always @(posedge ref_clk or negedge rstSync_n)
   begin
      if (!rstSync_n)
         irqEnable <= {`WD_IRQ_WIDTH{1'b0}};
      else if (hit(regAddr, `WD_OFF_IRQ_ENABLE, regWrite))
         irqEnable <= regWrData[`WD_IRQ_WIDTH-1:0];
   end

   // Level interrupt
   assign irq = |(irqStatus & irqEnable);

   ////////////////////////////////////////////////////////////////////
   // Read mux, data one cycle after the strobe
   always @*
   begin
      next_regRdData = 32'h0000_0000;
      if (regRead)
      begin
         case (regAddr)
            `WD_OFF_CTRL:
               next_regRdData[`WD_CTRL_WIDTH-1:0] = ctrl;
            `WD_OFF_MODULUS:
               next_regRdData[15:0] = modulus;
            `WD_OFF_COUNT:
               next_regRdData[15:0] = count;
            `WD_OFF_IRQ_STATUS:
               next_regRdData[`WD_IRQ_WIDTH-1:0] = irqStatus;
            `WD_OFF_IRQ_ENABLE:
               next_regRdData[`WD_IRQ_WIDTH-1:0] = irqEnable;
            default:
               // Service, clear and unmapped read as zero
               next_regRdData = 32'h0000_0000;
         endcase
      end
   end

   // Read data register, zero outside read answers
   always @(posedge ref_clk or negedge rstSync_n)
   begin
      if (!rstSync_n)
         regRdData <= 32'h0000_0000;
      else
         regRdData <= next_regRdData;
   end

endmodule
`default_nettype wire

// [testbench/wd_checker_sva.sv]
/*
 Port checker of the watchdog service timer.
 Assumes one clock and the bind in the testbench top file.
*/
`timescale 1ns/100ps
`default_nettype none
`include "watchdog_map.vh"
module wd_checker_sva
#(
   parameter PRESCALE_DIV = 4
)
(
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rst_n,
   // Register port
   input wire logic [7:0] regAddr,
   input wire logic [31:0] regWrData,
   input wire logic regWrite,
   input wire logic regRead,
   input wire logic [31:0] regRdData,
   // Mode flags
   input wire logic haltedMode,
   input wire logic waitMode,
   input wire logic dozeMode,
   // Outputs to the system
   input wire logic timeoutReset,
   input wire logic irq
);
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!rst_n);
   ////////////////////////////////////////////////////////////////////////
   // Strobe decodes
   wire rdCnt = regRead && regAddr == `WD_OFF_COUNT;
   wire rdMod = regRead && regAddr == `WD_OFF_MODULUS;
   wire wrMod = regWrite && regAddr == `WD_OFF_MODULUS;
   wire wrCnt = regWrite && regAddr == `WD_OFF_COUNT;
   wire wrKey = regWrite && regAddr == `WD_OFF_SERVICE;
   ////////////////////////////////////////////////////////////////////////
   rd_idle_a: assert property (!regRead |=> regRdData == 32'h0)
      else $error("read data not zero after idle cycle");
   upper_zero_a: assert property (regRead |=> regRdData[31:16] == 16'h0)
      else $error("read data upper half not zero");
   unmapped_read_a: assert property (regRead && regAddr == 8'h1c |=>
      regRdData == 32'h0)
      else $error("unmapped read not zero");
   to_sticky_a: assert property (timeoutReset |=> timeoutReset)
      else $error("timeout request dropped before reset");
   mod_load_a: assert property (wrMod && haltedMode ##1 rdCnt |=>
      {16'h0, regRdData[15:0]} == ($past(regWrData, 2) & 32'hffff))
      else $error("modulus write did not load the counter");
   mod_read_a: assert property (wrMod && haltedMode ##1 rdMod |=>
      regRdData == ($past(regWrData, 2) & 32'hffff))
      else $error("modulus read differs from written value");
   cnt_step_a: assert property (rdCnt ##1 rdCnt |=>
      regRdData <= $past(regRdData) && $past(regRdData) - regRdData <= 1)
      else $error("count moved by more than one step");
   cnt_write_a: assert property (rdCnt ##1 wrCnt ##1 rdCnt |=>
      regRdData <= $past(regRdData, 2) && $past(regRdData, 2) - regRdData <= 1)
      else $error("count write changed the counter");
   svc_reload_a: assert property (wrKey && regWrData[15:0] == 16'h5555
      ##1 wrKey && regWrData[15:0] == 16'haaaa ##1 rdMod ##1 rdCnt
      |=> regRdData == $past(regRdData))
      else $error("service did not reload the modulus");
   // Main scenarios reached
   svc_c: cover property (wrKey ##1 wrKey ##1 rdMod ##1 rdCnt);
   to_c: cover property ($rose(timeoutReset));
   irq_c: cover property ($rose(irq));
endmodule
`default_nettype wire

// [testbench/reset_ctrl_model.sv]
/*
 Reset controller model: passes power-on reset on and turns a standing
 timeout request into a one-cycle system reset, keeping a cause flag.
 Assumes the timeout request is a level on ref_clk.
*/
`timescale 1ns/100ps
`default_nettype none
module reset_ctrl_model
(
   // Clock and power-on request
   input wire logic ref_clk,
   input wire logic porReq_n,
   // Timer request
   input wire logic timeoutReset,
   // System reset and cause flag
   output wire logic rst_n,
   output logic wdCause
);
   // Cycles the request has stood
   logic [2:0] late;
   ////////////////////////////////////////////////////////////////////////
   // Cause flag survives the reset it causes
   always @(posedge ref_clk or negedge porReq_n)
   begin
      if (!porReq_n)
      begin
         late <= 3'h0;
         wdCause <= 1'b0;
      end
      else if (timeoutReset)
      begin
         late <= late + 3'h1;
         wdCause <= 1'b1;
      end
      else
         late <= 3'h0;
   end
   // System reset once the request stood four cycles
   assign rst_n = porReq_n && late != 3'h4;
endmodule
`default_nettype wire

// [testbench/testbench.sv]
/*
 Self-checking bench of the watchdog service timer: bus driver, random
 modulus and bad key, stop modes, interrupts and a full timeout.
 Assumes the design, checker and reset controller model are compiled.
*/
`timescale 1ns/100ps
`default_nettype none
`include "watchdog_map.vh"
module testbench;
   localparam DIV = 4;
   // Clock, power-on request and bus
   logic ref_clk = 1'b0;
   logic porReq_n = 1'b0;
   wire rst_n;
   wire wdCause;
   logic [7:0] regAddr = 8'h0;
   logic [31:0] regWrData = 32'h0;
   logic regWrite = 1'b0;
   logic regRead = 1'b0;
   wire [31:0] regRdData;
   logic haltedMode = 1'b0;
   logic waitMode = 1'b0;
   logic dozeMode = 1'b0;
   wire timeoutReset;
   wire irq;
   // Bookkeeping
   int fails = 0;
   int checkCount = 0;
   int i;
   logic [31:0] d;
   logic [31:0] e;
   logic [15:0] modVal;
   logic [15:0] bad;
   initial forever #4 ref_clk = ~ref_clk;
   watchdog_service_timer #(.PRESCALE_DIV(DIV)) DUT (.ref_clk(ref_clk),
      .rst_n(rst_n), .regAddr(regAddr), .regWrData(regWrData),
      .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData),
      .haltedMode(haltedMode), .waitMode(waitMode), .dozeMode(dozeMode),
      .timeoutReset(timeoutReset), .irq(irq));
   reset_ctrl_model RC (.ref_clk(ref_clk), .porReq_n(porReq_n),
      .timeoutReset(timeoutReset), .rst_n(rst_n), .wdCause(wdCause));
   ////////////////////////////////////////////////////////////////////////
   // Compare a word
   task automatic chk(input string what, input logic [31:0] exp,
      input logic [31:0] got);
      checkCount++;
      if (got !== exp)
      begin
         fails++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask
   // Expected count after n prescaler steps, floored at zero
   function automatic logic [31:0] stepped(input logic [31:0] c,
      input int n);
      stepped = (c > n) ? c - n : 32'h0;
   endfunction
   // One bus cycle
   task automatic acc(input logic w, input logic r, input logic [7:0] a,
      input logic [31:0] v);
      @(posedge ref_clk);
      regWrite <= w;
      regRead <= r;
      regAddr <= a;
      regWrData <= v;
   endtask
   // Idle cycle, then the data of the read before it
   task automatic take(output logic [31:0] v);
      acc(1'b0, 1'b0, 8'h0, 32'h0);
      #1 v = regRdData;
   endtask
   task automatic idle(input int n);
      repeat (n) acc(1'b0, 1'b0, 8'h0, 32'h0);
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] v);
      acc(1'b0, 1'b1, a, 32'h0);
      take(v);
   endtask
   task automatic rchk(input logic [7:0] a, input logic [31:0] exp,
      input string what);
      logic [31:0] v;
      rd(a, v);
      chk(what, exp, v);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      acc(1'b1, 1'b0, a, v);
      idle(1);
      #1;
   endtask
   task automatic close_out;
      $display("Counts: %0d checks, %0d mismatches", checkCount, fails);
      if (fails == 0 && checkCount > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial
   begin
      void'($urandom(32'haebe));
      modVal = 16'd24 + 16'($urandom % 16);
      bad = 16'($urandom) | 16'h0003;
      repeat (2) @(posedge ref_clk);
      porReq_n <= 1'b1;
      idle(4);
      rchk(`WD_OFF_CTRL, 32'he, "ctrl");
      rchk(`WD_OFF_MODULUS, 32'hffff, "modulus");
      rchk(8'h1c, 32'h0, "unmapped");
      idle(20);
      rchk(`WD_OFF_COUNT, 32'hffff, "count held");
      $display("test reset and disable done");
      @(posedge ref_clk);
      haltedMode <= 1'b1;
      wr(`WD_OFF_CTRL, 32'hf);
      acc(1'b1, 1'b0, `WD_OFF_MODULUS, {16'h0, ~modVal});
      acc(1'b0, 1'b1, `WD_OFF_COUNT, 32'h0);
      take(d);
      chk("count halted load", {16'h0, ~modVal}, d);
      acc(1'b1, 1'b0, `WD_OFF_MODULUS, {16'h0, bad});
      acc(1'b0, 1'b1, `WD_OFF_MODULUS, 32'h0);
      take(d);
      chk("modulus halted", {16'h0, bad}, d);
      @(posedge ref_clk);
      haltedMode <= 1'b0;
      wr(`WD_OFF_MODULUS, {16'h0, modVal});
      rchk(`WD_OFF_COUNT, {16'h0, modVal}, "count load");
      wr(`WD_OFF_MODULUS, 32'h7);
      rchk(`WD_OFF_MODULUS, {16'h0, modVal}, "modulus locked");
      rd(`WD_OFF_COUNT, d);
      idle(2 * DIV - 2);
      rd(`WD_OFF_COUNT, e);
      chk("count step", stepped(d, 2), e);
      acc(1'b0, 1'b1, `WD_OFF_COUNT, 32'h0);
      acc(1'b1, 1'b0, `WD_OFF_COUNT, 32'h0);
      acc(1'b0, 1'b1, `WD_OFF_COUNT, 32'h0);
      take(d);
      // Four cycles after e: one step, not the written zero
      chk("count write", stepped(e, 1), d);
      for (i = 0; i < 2; i++)
      begin
         @(posedge ref_clk);
         waitMode <= (i == 0);
         dozeMode <= (i == 1);
         rd(`WD_OFF_COUNT, d);
         idle(3 * DIV);
         rd(`WD_OFF_COUNT, e);
         chk("count stopped", d, e);
      end
      @(posedge ref_clk);
      waitMode <= 1'b0;
      dozeMode <= 1'b0;
      // Back-to-back count reads while running, watched by the checker
      acc(1'b0, 1'b1, `WD_OFF_COUNT, 32'h0);
      acc(1'b0, 1'b1, `WD_OFF_COUNT, 32'h0);
      take(d);
      $display("test modulus and count done");
      wr(`WD_OFF_SERVICE, 32'h5555);
      rd(`WD_OFF_COUNT, d);
      wr(`WD_OFF_SERVICE, 32'haaaa);
      rchk(`WD_OFF_COUNT, {16'h0, modVal}, "count serviced");
      acc(1'b1, 1'b0, `WD_OFF_SERVICE, 32'h5555);
      acc(1'b1, 1'b0, `WD_OFF_SERVICE, 32'haaaa);
      acc(1'b0, 1'b1, `WD_OFF_MODULUS, 32'h0);
      acc(1'b0, 1'b1, `WD_OFF_COUNT, 32'h0);
      take(d);
      chk("count reloaded", {16'h0, modVal}, d);
      idle(3 * DIV);
      wr(`WD_OFF_SERVICE, 32'haaaa);
      rd(`WD_OFF_COUNT, d);
      chk("lone key", 32'h1, {31'h0, d < {16'h0, modVal}});
      wr(`WD_OFF_SERVICE, 32'h5555);
      wr(`WD_OFF_SERVICE, {16'h0, bad});
      wr(`WD_OFF_SERVICE, 32'haaaa);
      rd(`WD_OFF_COUNT, d);
      chk("bad key", 32'h1, {31'h0, d < {16'h0, modVal}});
      $display("test service done");
      rchk(`WD_OFF_IRQ_STATUS, 32'h5, "status");
      chk("irq masked", 32'h0, {31'h0, irq});
      wr(`WD_OFF_IRQ_ENABLE, 32'h1);
      chk("irq raised", 32'h1, {31'h0, irq});
      wr(`WD_OFF_IRQ_CLEAR, 32'h1);
      chk("irq cleared", 32'h0, {31'h0, irq});
      rchk(`WD_OFF_IRQ_STATUS, 32'h4, "status cleared");
      wr(`WD_OFF_IRQ_ENABLE, 32'h2);
      $display("test interrupts done");
      i = 0;
      while (wdCause !== 1'b1 && i < 200 * DIV)
      begin
         @(posedge ref_clk);
         #1 i++;
      end
      chk("cause flag", 32'h1, {31'h0, wdCause});
      if (wdCause !== 1'b1)
         close_out();
      // Request still stands and the timeout interrupt is up
      chk("timeout request", 32'h1, {31'h0, timeoutReset});
      chk("irq timeout", 32'h1, {31'h0, irq});
      idle(8);
      rchk(`WD_OFF_MODULUS, 32'hffff, "modulus after timeout");
      $display("test timeout done");
      close_out();
   end
endmodule
bind watchdog_service_timer wd_checker_sva #(.PRESCALE_DIV(PRESCALE_DIV))
   SVA (.ref_clk(ref_clk), .rst_n(rst_n), .regAddr(regAddr),
   .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead),
   .regRdData(regRdData), .haltedMode(haltedMode), .waitMode(waitMode),
   .dozeMode(dozeMode), .timeoutReset(timeoutReset), .irq(irq));
`default_nettype wire
